// >>> scc_pkg.sv
// Package for the channel configuration register bank: offsets, fields, resets, types
package scc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SCC_OFS_CH2_VOLTAGE_TARGET = 8'h0C;
  localparam logic [7:0] SCC_OFS_CH2_CONTROL = 8'h0D;
  localparam logic [7:0] SCC_OFS_CH3_VOLTAGE_TARGET = 8'h0E;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SCC_RST_CH2_VOLTAGE_TARGET = 8'h00;
  localparam logic [7:0] SCC_RST_CH2_CONTROL = 8'h00;
  localparam logic [7:0] SCC_RST_CH3_VOLTAGE_TARGET = 8'h00;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int SCC_CTRL_DISCHARGE_BIT = 3;
  localparam int SCC_CTRL_SELECT_MSB = 2;
  localparam logic [7:0] SCC_CODE_FIRST_RESERVED = 8'h8D;
  localparam logic [2:0] SCC_SEL_LAST_SLOT = 3'h3;
  localparam logic [2:0] SCC_SEL_FORCE_OFF = 3'h4;
  localparam logic [2:0] SCC_SEL_FORCE_ON = 3'h6;
  localparam int SCC_SLOT_COUNT = 4;

  // Target voltage transfer: base plus step times code, in millivolts
  localparam logic [12:0] SCC_TARGET_BASE_MV = 13'h01F4;
  localparam logic [12:0] SCC_TARGET_STEP_MV = 13'h0019;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] reserved;
    logic dischargeEnable;
    logic [2:0] enableSelect;
  } scc_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } scc_req_t;

  typedef enum logic [1:0] {
    SCC_MODE_SLOT = 2'b00,
    SCC_MODE_OFF = 2'b01,
    SCC_MODE_ON = 2'b10
  } scc_mode_t;

  // Millivolts for a target code
  function automatic logic [12:0] scc_code_to_mv(input logic [7:0] code);
    logic [12:0] prod;
    prod = SCC_TARGET_STEP_MV * {5'h00, code};
    return SCC_TARGET_BASE_MV + prod;
  endfunction
endpackage

// >>> scc_channel_config_regs.sv
// Channel 2 configuration and channel 3 target register bank
//
// Function
// - The channel target field is an unsigned 8-bit code meaning 0.5V plus 25mV per step.
// - Enable selector values 0 to 3 place the channel in that power-sequencing slot.
// - Enable selector 4 or 5 forces the channel off, 6 or 7 forces it on.
// - With discharge bit 3 set, a disabled channel gets the internal discharge load.
`timescale 1ns/100ps
module scc_channel_config_regs
  import scc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire scc_pkg::scc_req_t regReq,
  input wire logic [scc_pkg::SCC_SLOT_COUNT-1:0] seqSlotActive,
  output logic [7:0] regRdData,
  output logic ch2Enabled,
  output logic ch2DischargeOn,
  output logic [7:0] ch2TargetCode,
  output logic [12:0] ch2TargetMv,
  output logic ch2CodeReserved,
  output logic [7:0] ch3TargetCode,
  output logic [12:0] ch3TargetMv
);
  import scc_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Register picked out by an offset on the register port
  typedef enum logic [1:0] {
    SCC_REG_NONE = 2'b00,
    SCC_REG_CH2_TARGET = 2'b01,
    SCC_REG_CH2_CONTROL = 2'b10,
    SCC_REG_CH3_TARGET = 2'b11
  } scc_reg_sel_t;

  // One map serves the write and the read path, so the two can never disagree
  function automatic scc_reg_sel_t scc_decode_offset(input logic [7:0] ofs);
    scc_reg_sel_t sel;
    case (ofs)
      SCC_OFS_CH2_VOLTAGE_TARGET: sel = SCC_REG_CH2_TARGET;
      SCC_OFS_CH2_CONTROL: sel = SCC_REG_CH2_CONTROL;
      SCC_OFS_CH3_VOLTAGE_TARGET: sel = SCC_REG_CH3_TARGET;
      default: sel = SCC_REG_NONE;
    endcase
    return sel;
  endfunction

  // Selector to mode: four slot codes, then two off codes, then two on codes
  function automatic scc_mode_t scc_decode_select(input logic [2:0] sel);
    scc_mode_t decoded;
    if (sel <= SCC_SEL_LAST_SLOT) begin
      decoded = SCC_MODE_SLOT;
    end else if (sel >= SCC_SEL_FORCE_ON) begin
      decoded = SCC_MODE_ON;
    end else begin
      decoded = SCC_MODE_OFF;
    end
    return decoded;
  endfunction

  // Codes past the top of the linear range are kept but marked
  function automatic logic scc_code_is_reserved(input logic [7:0] code);
    return code >= SCC_CODE_FIRST_RESERVED;
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] ch2Target_reg, ch2Target_next;
  scc_ctrl_t ch2Ctrl_reg, ch2Ctrl_next;
  logic [7:0] ch3Target_reg, ch3Target_next;
  scc_reg_sel_t regSel;
  assign regSel = scc_decode_offset(regReq.addr);

  always_comb begin
    ch2Target_next = ch2Target_reg;
    ch2Ctrl_next = ch2Ctrl_reg;
    ch3Target_next = ch3Target_reg;
    // Writes to unmapped offsets are dropped; all eight bits are stored as read-write
    if (regReq.wrEn) begin
      unique case (regSel)
        SCC_REG_CH2_TARGET: ch2Target_next = regReq.wrData;
        SCC_REG_CH2_CONTROL: ch2Ctrl_next = scc_ctrl_t'(regReq.wrData);
        SCC_REG_CH3_TARGET: ch3Target_next = regReq.wrData;
        SCC_REG_NONE: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ch2Target_reg <= SCC_RST_CH2_VOLTAGE_TARGET;
      ch2Ctrl_reg <= scc_ctrl_t'(SCC_RST_CH2_CONTROL);
      ch3Target_reg <= SCC_RST_CH3_VOLTAGE_TARGET;
    end else begin
      ch2Target_reg <= ch2Target_next;
      ch2Ctrl_reg <= ch2Ctrl_next;
      ch3Target_reg <= ch3Target_next;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdData_reg, rdData_next;

  always_comb begin
    rdData_next = rdData_reg;
    // Captured so the serial engine sees a stable byte; a write in the same cycle reads old
    if (regReq.rdEn) begin
      unique case (regSel)
        SCC_REG_CH2_TARGET: rdData_next = ch2Target_reg;
        SCC_REG_CH2_CONTROL: rdData_next = ch2Ctrl_reg;
        SCC_REG_CH3_TARGET: rdData_next = ch3Target_reg;
        // Unmapped offsets answer zero rather than the last byte read
        SCC_REG_NONE: rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ****************************************
  // Channel enable
  // ****************************************
  scc_mode_t mode;
  logic en_reg, en_next;

  always_comb begin
    mode = scc_decode_select(ch2Ctrl_reg.enableSelect);
    // Slot status is a same-clock level from the on/off controller, so no synchroniser
    unique case (mode)
      SCC_MODE_SLOT: en_next = seqSlotActive[ch2Ctrl_reg.enableSelect[1:0]];
      SCC_MODE_OFF: en_next = 1'b0;
      SCC_MODE_ON: en_next = 1'b1;
      default: en_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
    end
  end

  // ****************************************
  // Discharge control
  // ****************************************
  logic disch_reg, disch_next;

  always_comb begin
    // Taken from the next enable so load and enable change on one edge
    // Load only while the channel is off; never fights a running output
    disch_next = ch2Ctrl_reg.dischargeEnable && !en_next;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      disch_reg <= 1'b0;
    end else begin
      disch_reg <= disch_next;
    end
  end

  // ****************************************
  // Target voltage in millivolts
  // ****************************************
  // Registered so the converter sees one settled value per clock
  logic [12:0] ch2Mv_reg, ch2Mv_next;
  logic [12:0] ch3Mv_reg, ch3Mv_next;

  always_comb begin
    ch2Mv_next = scc_code_to_mv(ch2Target_reg);
    ch3Mv_next = scc_code_to_mv(ch3Target_reg);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Matches the reset code of zero
      ch2Mv_reg <= SCC_TARGET_BASE_MV;
      ch3Mv_reg <= SCC_TARGET_BASE_MV;
    end else begin
      ch2Mv_reg <= ch2Mv_next;
      ch3Mv_reg <= ch3Mv_next;
    end
  end

  // ****************************************
  // Reserved code flag
  // ****************************************
  logic resv_reg, resv_next;

  always_comb begin
    // Reserved codes are stored as written; flagged so the converter can clamp
    resv_next = scc_code_is_reserved(ch2Target_reg);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      resv_reg <= 1'b0;
    end else begin
      resv_reg <= resv_next;
    end
  end

  // ****************************************
  // Output ports
  // ****************************************
  // Every port is a flip-flop output
  assign regRdData = rdData_reg;
  assign ch2Enabled = en_reg;
  assign ch2DischargeOn = disch_reg;
  assign ch2TargetCode = ch2Target_reg;
  assign ch2TargetMv = ch2Mv_reg;
  assign ch2CodeReserved = resv_reg;
  assign ch3TargetCode = ch3Target_reg;
  assign ch3TargetMv = ch3Mv_reg;
endmodule

// >>> scc_regs_sva.sv
// Checker for the channel configuration register bank
`timescale 1ns/100ps
module scc_regs_sva
  import scc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire scc_pkg::scc_req_t regReq,
  input wire logic [3:0] seqSlotActive,
  input wire logic ch2Enabled,
  input wire logic ch2DischargeOn,
  input wire logic [7:0] ch2TargetCode,
  input wire logic [12:0] ch2TargetMv
);
  // Shadow of the control register, since it is not visible at the ports
  logic [7:0] ctrlReg, ctrlNext;
  logic slotOn;
  assign slotOn = seqSlotActive[ctrlReg[1:0]];
  always_comb begin
    ctrlNext = ctrlReg;
    if (regReq.wrEn && regReq.addr == SCC_OFS_CH2_CONTROL) ctrlNext = regReq.wrData;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ctrlReg <= 8'h00;
    else ctrlReg <= ctrlNext;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_mv_linear:
    assert property ($past(nrst) |-> ch2TargetMv == 13'h01F4 + 13'h0019 * {5'h00, $past(ch2TargetCode)})
    else $error("target millivolts wrong");
  a_slot_follow:
    assert property ($past(nrst) && !$past(ctrlReg[2]) |-> ch2Enabled == $past(slotOn))
    else $error("channel does not follow its slot");
  a_force_state:
    assert property ($past(nrst) && $past(ctrlReg[2]) |-> ch2Enabled == $past(ctrlReg[1]))
    else $error("forced state wrong");
  a_discharge_load:
    assert property ($past(nrst) |-> ch2DischargeOn == ($past(ctrlReg[3]) && !ch2Enabled))
    else $error("discharge load wrong");
  cover property (ch2DischargeOn);
  cover property (ch2Enabled && ctrlReg[2:1] == 2'h3);
  cover property (ch2Enabled && !ctrlReg[2]);
endmodule
bind scc_channel_config_regs scc_regs_sva scc_regs_sva_i (.clk_sys, .nrst, .regReq,
  .seqSlotActive, .ch2Enabled, .ch2DischargeOn, .ch2TargetCode, .ch2TargetMv);

// >>> scc_channel_config_regs_tb.sv
// Testbench for the channel configuration register bank
`timescale 1ns/100ps
module scc_channel_config_regs_tb;
  import scc_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0;
  scc_req_t regReq = '0;
  logic [3:0] seqSlotActive = 4'h0;
  logic [7:0] regRdData, ch2TargetCode, ch3TargetCode, code;
  logic ch2Enabled, ch2DischargeOn, ch2CodeReserved;
  logic [12:0] ch2TargetMv, ch3TargetMv;
  int fails = 0, nCompared = 0, cyc = 0;
  // Rows: control byte, slot status, expected enable, expected discharge
  logic [13:0] rows [9] = '{{8'h00, 4'h1, 2'h2}, {8'h09, 4'h1, 2'h1}, {8'h0A, 4'h4, 2'h2},
    {8'h0B, 4'h7, 2'h1}, {8'h0C, 4'hF, 2'h1}, {8'h05, 4'hF, 2'h0}, {8'h0E, 4'h0, 2'h2},
    {8'h07, 4'h0, 2'h2}, {8'hF3, 4'h8, 2'h2}};
  logic [7:0] codes [4] = '{8'h00, 8'h8C, 8'h8D, 8'hFF};
  scc_channel_config_regs scc_channel_config_regs_i (.clk_sys, .nrst, .regReq, .seqSlotActive,
    .regRdData, .ch2Enabled, .ch2DischargeOn, .ch2TargetCode, .ch2TargetMv, .ch2CodeReserved,
    .ch3TargetCode, .ch3TargetMv);
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regReq = '{a, 1'b1, 1'b0, d};
    @(negedge clk_sys);
    regReq.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    regReq = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk_sys);
    regReq.rdEn = 1'b0;
    chk({5'h00, regRdData}, {5'h00, e});
  endtask
  task automatic close_out;
    $display("compared %0d fails %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    chk(ch2TargetMv, 13'h01F4);
    for (int a = 12; a < 15; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 9; i++) begin
      seqSlotActive = rows[i][5:2];
      wr(SCC_OFS_CH2_CONTROL, rows[i][13:6]);
      @(negedge clk_sys);
      chk({12'h000, ch2Enabled}, {12'h000, rows[i][1]});
      chk({12'h000, ch2DischargeOn}, {12'h000, rows[i][0]});
      // Bias low-power return after enable is a host step in another bank
      rd(SCC_OFS_CH2_CONTROL, rows[i][13:6]);
    end
    for (int i = 0; i < 4; i++) begin
      code = codes[i];
      wr(SCC_OFS_CH2_VOLTAGE_TARGET, code);
      wr(SCC_OFS_CH3_VOLTAGE_TARGET, ~code);
      @(negedge clk_sys);
      chk(ch2TargetMv, 13'h01F4 + 13'h0019 * {5'h00, code});
      chk(ch3TargetMv, 13'h01F4 + 13'h0019 * {5'h00, ~code});
      chk({5'h00, ch2TargetCode}, {5'h00, code});
      chk({5'h00, ch3TargetCode}, {5'h00, ~code});
      chk({12'h000, ch2CodeReserved}, {12'h000, code >= SCC_CODE_FIRST_RESERVED});
      rd(SCC_OFS_CH3_VOLTAGE_TARGET, ~code);
      rd(SCC_OFS_CH2_VOLTAGE_TARGET, code);
    end
    // Unmapped offset must neither store nor answer
    wr(8'h0F, 8'h55);
    rd(8'h0F, 8'h00);
    chk({5'h00, ch3TargetCode}, {5'h00, ~code});
    // Mid-run reset from an enabled channel holding a reserved code
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    chk({12'h000, ch2Enabled}, 13'h0000);
    chk({12'h000, ch2CodeReserved}, 13'h0000);
    chk(ch2TargetMv, SCC_TARGET_BASE_MV);
    rd(SCC_OFS_CH2_CONTROL, SCC_RST_CH2_CONTROL);
    close_out;
  end
endmodule
